// *** include/cwsc_defines.svh ***
// register offsets, field positions, reset values of the waveform block
// assumes an 8-bit APB byte address, one 32-bit word per register
`ifndef CWSC_DEFINES_SVH
`define CWSC_DEFINES_SVH

// byte offsets
`define CWSC_OFS_CTRL0 8'h00
`define CWSC_OFS_CTRL1 8'h04
`define CWSC_OFS_SHUT 8'h08
`define CWSC_OFS_DBR 8'h0C
`define CWSC_OFS_DBF 8'h10
`define CWSC_OFS_STAT 8'h14

// reset values
`define CWSC_RST_CTRL0 8'h00
`define CWSC_RST_CTRL1 8'h00
`define CWSC_RST_SHUT 8'h00
`define CWSC_RST_DB 6'h00

// writable bits per register
`define CWSC_CTRL0_MASK 8'hF9
`define CWSC_CTRL1_MASK 8'h33
`define CWSC_SHUT_MASK 8'hC3

// control one fields
`define CWSC_BIT_OVR_B 5
`define CWSC_BIT_OVR_A 4
`define CWSC_BIT_SRC_HI 1
`define CWSC_BIT_SRC_LO 0

// shutdown control fields
`define CWSC_BIT_REQ 7
`define CWSC_BIT_ARS 6
`define CWSC_BIT_SDS_HI 1
`define CWSC_BIT_SDS_LO 0

// status fields
`define CWSC_BIT_ST_A 0
`define CWSC_BIT_ST_B 1
`define CWSC_BIT_ST_FAULT 2
`define CWSC_BIT_ST_RUN 3

`endif

// *** include/cwsc_pkg.sv ***
// types shared by the waveform block and its dead-band module
// assumes the defines header is compiled alongside
package cwsc_pkg;

  // control register zero, msb first
  typedef struct packed {
    logic module_enable;
    logic out_b_pin_enable;
    logic out_a_pin_enable;
    logic out_b_polarity;
    logic out_a_polarity;
    logic [1:0] unused;
    logic deadband_clock_select;
  } cwsc_ctrl0_t;

  // a pair of complementary drives
  typedef struct packed {
    logic b;
    logic a;
  } cwsc_pair_t;

  // output sequencing
  typedef enum logic [1:0] {
    CWSC_SHUT,
    CWSC_WAIT_EDGE,
    CWSC_RUN
  } cwsc_state_t;

endpackage

// *** rtl/cwsc_deadband.sv ***
// dead-band sequencer: turns one source level into two non-overlapping
// drives; assumes a synchronised source and a one-cycle count tick
`timescale 1ns/1ps
module cwsc_deadband (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic run, // module enabled
  input wire logic src, // synchronised source level
  input wire logic tick, // one dead-band clock period
  input wire logic [5:0] rise_count, // delay before a turns on
  input wire logic [5:0] fall_count, // delay before b turns on
  output cwsc_pkg::cwsc_pair_t drive, // raw drives, active high
  output logic rise_edge // source rising edge, pulse
);
  import cwsc_pkg::*;

  logic src_prev;
  logic [5:0] cnt;
  logic pend_a;
  logic pend_b;
  cwsc_pair_t next_drive;
  logic [5:0] next_cnt;
  logic next_pend_a;
  logic next_pend_b;
  logic fall_edge;
  logic [5:0] cnt_inc;

  // edge detection on the source
  assign rise_edge = run & src & ~src_prev;
  assign fall_edge = run & ~src & src_prev;
  assign cnt_inc = 6'(cnt + 6'h01);

  // edge starts a delay; the count completes the opposite turn-on
  always_comb begin
    next_drive = drive;
    next_cnt = cnt;
    next_pend_a = pend_a;
    next_pend_b = pend_b;
    if (!run) begin
      next_drive = '0;
      next_cnt = '0;
      next_pend_a = 1'b0;
      next_pend_b = 1'b0;
    end else if (rise_edge) begin
      next_drive.b = 1'b0;
      next_drive.a = (rise_count == 6'h00);
      next_pend_a = (rise_count != 6'h00);
      next_pend_b = 1'b0;
      next_cnt = '0;
    end else if (fall_edge) begin
      next_drive.a = 1'b0;
      next_drive.b = (fall_count == 6'h00);
      next_pend_b = (fall_count != 6'h00);
      next_pend_a = 1'b0;
      next_cnt = '0;
    end else if (tick && (pend_a || pend_b)) begin
      next_cnt = cnt_inc;
      if (pend_a && cnt_inc == rise_count) begin
        next_drive.a = 1'b1;
        next_pend_a = 1'b0;
      end
      if (pend_b && cnt_inc == fall_count) begin
        next_drive.b = 1'b1;
        next_pend_b = 1'b0;
      end
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev <= 1'b0;
      cnt <= '0;
      pend_a <= 1'b0;
      pend_b <= 1'b0;
      drive <= '0;
    end else begin
      src_prev <= src;
      cnt <= next_cnt;
      pend_a <= next_pend_a;
      pend_b <= next_pend_b;
      drive <= next_drive;
    end
  end

endmodule

// *** rtl/cwsc_top.sv ***
// complementary waveform generator with shutdown override and restart,
// registers on APB; assumes pins and oscillator arrive asynchronously
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "cwsc_defines.svh"
module cwsc_top (
  input wire logic pclk, // system clock, 20 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [3:0] source_in, // four waveform sources
  input wire logic [1:0] shutdown_in, // two shutdown inputs
  input wire logic internal_fast_oscillator, // 16 MHz oscillator
  output logic out_a, // pin level a
  output logic out_b, // pin level b
  output logic out_a_oe_n, // pin a driven when low
  output logic out_b_oe_n // pin b driven when low
);
  import cwsc_pkg::*;

  // register state
  cwsc_ctrl0_t ctrl0;
  logic [7:0] ctrl1;
  logic shutdown_request;
  logic auto_restart_enable;
  logic [1:0] shutdown_select;
  logic [5:0] rise_deadband_count;
  logic [5:0] fall_deadband_count;
  cwsc_state_t state;
  cwsc_state_t next_state;

  // synchronisers: first stage read only by the second
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  logic osc_prev;

  // bus decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_ctrl0 = (paddr == `CWSC_OFS_CTRL0);
  wire hit_ctrl1 = (paddr == `CWSC_OFS_CTRL1);
  wire hit_shut = (paddr == `CWSC_OFS_SHUT);
  wire hit_dbr = (paddr == `CWSC_OFS_DBR);
  wire hit_dbf = (paddr == `CWSC_OFS_DBF);
  wire hit_stat = (paddr == `CWSC_OFS_STAT);
  wire hit_any = hit_ctrl0 | hit_ctrl1 | hit_shut | hit_dbr | hit_dbf
                 | hit_stat;
  wire wr = access & pwrite & hit_any;
  wire wr_ctrl0 = wr & hit_ctrl0;
  wire wr_ctrl1 = wr & hit_ctrl1;
  wire wr_shut = wr & hit_shut;
  wire wr_dbr = wr & hit_dbr;
  wire wr_dbf = wr & hit_dbf;

  // zero wait states; unmapped address answers with an error
  assign pready = 1'b1;
  assign pslverr = access & ~hit_any;

  // synchronised pins
  wire [3:0] src_sync = pin_sync[3:0];
  wire [1:0] sd_sync = pin_sync[5:4];
  wire osc_sync = pin_sync[6];

  // input source select
  wire [1:0] src_sel = ctrl1[`CWSC_BIT_SRC_HI:`CWSC_BIT_SRC_LO];
  wire src_level = src_sync[src_sel];

  // dead-band clock: every pclk, or each oscillator rising edge
  wire osc_edge = osc_sync & ~osc_prev;
  wire db_tick = ctrl0.deadband_clock_select ? osc_edge : 1'b1;

  // level-sensitive fault from the selected shutdown inputs
  wire fault = |(sd_sync & shutdown_select);

  // requests to set or clear the shutdown request bit
  wire sw_set = wr_shut & pwdata[`CWSC_BIT_REQ];
  wire sw_clr = wr_shut & ~pwdata[`CWSC_BIT_REQ];
  wire auto_clr = auto_restart_enable & shutdown_request;
  wire any_clr = (sw_clr | auto_clr) & ~fault;
  wire any_set = sw_set | fault;
  // a set in the same cycle as a clear wins
  wire next_request = any_set ? 1'b1 :
                      (any_clr ? 1'b0 : shutdown_request);

  // shutdown is active on the request bit or on a live fault
  wire shut_now = shutdown_request | fault;

  // dead-band sequencer
  cwsc_pair_t raw;
  logic rise_edge;

  cwsc_deadband i_cwsc_deadband (
    .pclk(pclk),
    .presetn(presetn),
    .run(ctrl0.module_enable),
    .src(src_level),
    .tick(db_tick),
    .rise_count(rise_deadband_count),
    .fall_count(fall_deadband_count),
    .drive(raw),
    .rise_edge(rise_edge)
  );

  // restart sequencing: shutdown, then wait for a source rising edge
  always_comb begin
    next_state = state;
    unique case (state)
      CWSC_SHUT: begin
        if (!shut_now && !sw_set) begin
          next_state = CWSC_WAIT_EDGE;
        end
      end
      CWSC_WAIT_EDGE: begin
        if (rise_edge) begin
          next_state = CWSC_RUN;
        end
      end
      CWSC_RUN: begin
        next_state = CWSC_RUN;
      end
      default: next_state = CWSC_SHUT;
    endcase
    if (!ctrl0.module_enable || shut_now || sw_set) begin
      next_state = CWSC_SHUT;
    end
  end

  // pin levels: overrides raw in shutdown, polarity only while running
  wire running = (next_state == CWSC_RUN);
  wire ovr_a = ctrl1[`CWSC_BIT_OVR_A];
  wire ovr_b = ctrl1[`CWSC_BIT_OVR_B];
  wire run_a = raw.a ^ ctrl0.out_a_polarity;
  wire run_b = raw.b ^ ctrl0.out_b_polarity;
  wire next_a = running ? run_a : ovr_a;
  wire next_b = running ? run_b : ovr_b;
  wire next_oe_a_n = ~(ctrl0.module_enable & ctrl0.out_a_pin_enable);
  wire next_oe_b_n = ~(ctrl0.module_enable & ctrl0.out_b_pin_enable);

  // read mux
  wire [7:0] shut_rd = {shutdown_request, auto_restart_enable, 4'h0,
                        shutdown_select};
  wire [7:0] stat_rd = {4'h0, (state == CWSC_RUN), fault, out_b, out_a};
  wire [7:0] rd_value = hit_ctrl0 ? ctrl0 :
                        hit_ctrl1 ? ctrl1 :
                        hit_shut ? shut_rd :
                        hit_dbr ? {2'h0, rise_deadband_count} :
                        hit_dbf ? {2'h0, fall_deadband_count} :
                        hit_stat ? stat_rd : 8'h00;

  // masked write data
  wire [7:0] ctrl0_wval = pwdata[7:0] & `CWSC_CTRL0_MASK;
  wire [7:0] ctrl1_wval = pwdata[7:0] & `CWSC_CTRL1_MASK;

  // pin synchronisers and oscillator edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
      osc_prev <= 1'b0;
    end else begin
      pin_meta <= {internal_fast_oscillator, shutdown_in, source_in};
      pin_sync <= pin_meta;
      osc_prev <= osc_sync;
    end
  end

  // control register zero and one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0 <= `CWSC_RST_CTRL0;
      ctrl1 <= `CWSC_RST_CTRL1;
    end else begin
      if (wr_ctrl0) begin
        ctrl0 <= ctrl0_wval;
      end
      if (wr_ctrl1) begin
        ctrl1 <= ctrl1_wval;
      end
    end
  end

  // shutdown control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutdown_request <= 1'(`CWSC_RST_SHUT >> `CWSC_BIT_REQ);
      auto_restart_enable <= 1'b0;
      shutdown_select <= 2'h0;
    end else begin
      shutdown_request <= next_request;
      if (wr_shut) begin
        auto_restart_enable <= pwdata[`CWSC_BIT_ARS];
        shutdown_select <= pwdata[`CWSC_BIT_SDS_HI:`CWSC_BIT_SDS_LO];
      end
    end
  end

  // dead-band counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_deadband_count <= `CWSC_RST_DB;
      fall_deadband_count <= `CWSC_RST_DB;
    end else begin
      if (wr_dbr) begin
        rise_deadband_count <= pwdata[5:0];
      end
      if (wr_dbf) begin
        fall_deadband_count <= pwdata[5:0];
      end
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      prdata <= {24'h000000, rd_value};
    end
  end

  // sequencer state and pins; reset starts from shutdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CWSC_SHUT;
      out_a <= 1'b0;
      out_b <= 1'b0;
      out_a_oe_n <= 1'b1;
      out_b_oe_n <= 1'b1;
    end else begin
      state <= next_state;
      out_a <= next_a;
      out_b <= next_b;
      out_a_oe_n <= next_oe_a_n;
      out_b_oe_n <= next_oe_b_n;
    end
  end

endmodule

// *** sim/cwsc_bench.sv ***
// self-checking bench: apb setup, shutdown, restart, dead band
// assumes zero-wait apb and registered pins of the waveform block
`timescale 1ns/1ps
module cwsc_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q, prdata;
  logic [3:0] source_in = 4'h0;
  logic [1:0] shutdown_in = 2'h0, dir = 2'h3;
  logic osc = 0, osc_run = 0, e, pready, pslverr, out_a, out_b;
  logic out_a_oe_n, out_b_oe_n, pin_a, pin_b;
  int errors = 0, checks = 0;
  // system clock and oscillator gated by osc_run
  initial forever #25 pclk = ~pclk;
  initial forever #31.25 if (osc_run) osc = ~osc;
  cwsc_top i_cwsc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .source_in(source_in), .shutdown_in(shutdown_in),
    .internal_fast_oscillator(osc), .out_a(out_a), .out_b(out_b),
    .out_a_oe_n(out_a_oe_n), .out_b_oe_n(out_b_oe_n));
  cwsc_switch_model i_cwsc_switch_model (.out_a(out_a), .out_b(out_b),
    .out_a_oe_n(out_a_oe_n),
    .out_b_oe_n(out_b_oe_n), .pin_direction(dir), .pin_a(pin_a),
    .pin_b(pin_b));
  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // one apb transfer, request held until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task pins(input logic [1:0] x);
    chk({30'h0, pin_b, pin_a}, {30'h0, x});
  endtask
  task src(input logic v);
    @(posedge pclk);
    source_in <= {3'h0, v};
  endtask
  task fault(input logic v);
    @(posedge pclk);
    shutdown_in <= {1'b0, v};
  endtask
  task tally_and_finish;
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #200000;
    errors++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rd(8'h00, 32'h00);
    wr(8'h00, 32'hFF);
    rd(8'h00, 32'hF9);
    rd(8'h40, 32'h00);
    chk({31'h0, e}, 32'h1);
    wr(8'h00, 32'h00);
    wr(8'h0C, 32'h00);
    wr(8'h10, 32'h00);
    wr(8'h08, 32'h81);
    wr(8'h04, 32'h20);
    wr(8'h00, 32'hE8);
    dir <= 2'h0;
    tick(3);
    pins(2'b10);
    chk({30'h0, out_b_oe_n, out_a_oe_n}, 32'h0);
    wr(8'h08, 32'h01);
    tick(8);
    pins(2'b10);
    src(1);
    tick(6);
    pins(2'b00);
    src(0);
    tick(6);
    pins(2'b11);
    wr(8'h08, 32'h81);
    tick(2);
    pins(2'b10);
    fault(1);
    tick(5);
    wr(8'h08, 32'h01);
    rd(8'h08, 32'h81);
    fault(0);
    tick(5);
    rd(8'h08, 32'h81);
    pins(2'b10);
    wr(8'h08, 32'h01);
    rd(8'h08, 32'h01);
    src(1);
    tick(6);
    src(0);
    tick(6);
    pins(2'b11);
    wr(8'h08, 32'h41);
    fault(1);
    tick(5);
    pins(2'b10);
    rd(8'h08, 32'hC1);
    fault(0);
    tick(5);
    rd(8'h08, 32'h41);
    pins(2'b10);
    src(1);
    tick(6);
    pins(2'b00);
    src(0);
    tick(6);
    pins(2'b11);
    wr(8'h08, 32'h01);
    wr(8'h0C, 32'h04);
    src(1);
    tick(4);
    pins(2'b01);
    tick(10);
    pins(2'b00);
    src(0);
    tick(6);
    wr(8'h00, 32'hE9);
    src(1);
    tick(14);
    pins(2'b01);
    osc_run = 1;
    tick(30);
    pins(2'b00);
    osc_run = 0;
    wr(8'h00, 32'h68);
    tick(3);
    chk({30'h0, out_b_oe_n, out_a_oe_n}, 32'h3);
    // source 2, shutdown input 1, inverted b, override a high
    wr(8'h04, 32'h12);
    wr(8'h0C, 32'h00);
    wr(8'h08, 32'h82);
    wr(8'h00, 32'hF0);
    tick(3);
    pins(2'b01);
    wr(8'h08, 32'h02);
    @(posedge pclk);
    source_in <= 4'h4;
    tick(6);
    pins(2'b11);
    @(posedge pclk);
    shutdown_in <= 2'h2;
    tick(5);
    pins(2'b01);
    rd(8'h08, 32'h82);
    tally_and_finish;
  end
endmodule

// *** sim/cwsc_checker.sv ***
// concurrent checks on the waveform block ports
// assumes apb writes land at the access edge, registered pins
`timescale 1ns/1ps
module cwsc_checker (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [3:0] source_in, // waveform sources
  input wire logic [1:0] shutdown_in, // shutdown inputs
  input wire logic internal_fast_oscillator, // 16 MHz level
  input wire logic out_a, // pin level a
  input wire logic out_b, // pin level b
  input wire logic out_a_oe_n, // pin a driven when low
  input wire logic out_b_oe_n // pin b driven when low
);
  logic [7:0] c0, c1, sh;
  logic [2:0] flt;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire ena = c0[7] && c0[5];
  wire enb = c0[7] && c0[6];
  wire fault = (shutdown_in & sh[1:0]) != 2'h0;
  wire bad = paddr > 8'h14 || paddr[1:0] != 2'h0;
  // shadow copies of written registers, fault run length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0 <= 8'h00;
      c1 <= 8'h00;
      sh <= 8'h00;
      flt <= 3'h0;
    end else begin
      if (wr && paddr == 8'h00) c0 <= pwdata[7:0];
      if (wr && paddr == 8'h04) c1 <= pwdata[7:0];
      if (wr && paddr == 8'h08) sh <= pwdata[7:0];
      flt <= !fault ? 3'h0 : (flt == 3'h7 ? flt : flt + 3'h1);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_oe_a; out_a_oe_n == !$past(ena); endproperty
  a_oe_a: assert property (p_oe_a)
    else $error("pin a enable wrong");
  property p_oe_b; out_b_oe_n == !$past(enb); endproperty
  a_oe_b: assert property (p_oe_b)
    else $error("pin b enable wrong");
  property p_ctrl0_rd;
    rd && paddr == 8'h00 |-> prdata == {24'h0, $past(c0) & 8'hF9};
  endproperty
  a_ctrl0_rd: assert property (p_ctrl0_rd)
    else $error("control zero readback wrong");
  property p_req_set;
    wr && paddr == 8'h08 && pwdata[7] |-> ##2 out_a == c1[4] && out_b == c1[5];
  endproperty
  a_req_set: assert property (p_req_set)
    else $error("request did not force overrides");
  property p_fault; flt >= 3'h4 |-> out_a == c1[4] && out_b == c1[5]; endproperty
  a_fault: assert property (p_fault)
    else $error("fault did not force overrides");
  property p_hold; rd && paddr == 8'h08 && flt >= 3'h5 |-> prdata[7]; endproperty
  a_hold: assert property (p_hold)
    else $error("request cleared under fault");
  property p_err; acc && bad |-> pslverr; endproperty
  a_err: assert property (p_err)
    else $error("unmapped access not flagged");
  property p_noerr; !acc || !bad |-> !pslverr && pready; endproperty
  a_noerr: assert property (p_noerr)
    else $error("error or ready wrong on good access");
endmodule
bind cwsc_top cwsc_checker i_cwsc_checker (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .source_in(source_in), .shutdown_in(shutdown_in),
  .internal_fast_oscillator(internal_fast_oscillator), .out_a(out_a),
  .out_b(out_b), .out_a_oe_n(out_a_oe_n), .out_b_oe_n(out_b_oe_n));

// *** sim/cwsc_switch_model.sv ***
// model of the switch drivers on the two output pins
// assumes pin direction comes from the bench, 1 keeps a pin an input
`timescale 1ns/1ps
module cwsc_switch_model (
  input wire logic out_a, // level a
  input wire logic out_b, // level b
  input wire logic out_a_oe_n, // a driven when low
  input wire logic out_b_oe_n, // b driven when low
  input wire logic [1:0] pin_direction, // 1 means input
  output logic pin_a, // level seen by switch a
  output logic pin_b // level seen by switch b
);
  // drive reaches a switch only when enabled and direction is out;
  // a released pin shows the inverse, so a stale level never passes
  assign pin_a = (!out_a_oe_n && !pin_direction[0]) ? out_a : ~out_a;
  assign pin_b = (!out_b_oe_n && !pin_direction[1]) ? out_b : ~out_b;
endmodule
